// *** src/ppsc_consts.vh ***
// constants for the port power switch control block
`ifndef PPSC_CONSTS_VH
`define PPSC_CONSTS_VH
`define PPSC_CLK_MHZ         50
`define PPSC_LIM_W           3
`define PPSC_LIM_MIN         3'h0
`define PPSC_LIM_DCP_MAX     3'h4
`define PPSC_KNEE_W          8
`define PPSC_KNEE_TRIP       8'h0c
`define PPSC_KNEE_NORMAL     8'hff
`define PPSC_MODE_PASS       2'h0
`define PPSC_MODE_DCP        2'h1
`define PPSC_MODE_CDP        2'h2
`define PPSC_MODE_DCE        2'h3
`define PPSC_SHORT_US        1
`define PPSC_RISE_US         1000
`define PPSC_STEP_MS         200
`define PPSC_DISCH_MS        200
`define PPSC_RECOVER_MS      200
`endif

// *** src/ppsc_timer.v ***
// one-shot down counter with done pulse
`timescale 1ns/1ps
module ppsc_timer #(
   parameter W = 24
) (
   // clock and reset
   input  wire         clk,
   input  wire         nrst,
   // control
   input  wire         start,
   input  wire [W-1:0] load,
   input  wire         abort,
   // status
   output reg          busy,
   output reg          done
);
   reg [W-1:0] count;
   always @(posedge clk) begin
      if (!nrst) begin
         count <= {W{1'b0}};
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
         end else if (start) begin
            count <= load;
            busy  <= 1'b1;
         end else if (busy) begin
            if (count <= {{(W-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // ppsc_timer

// *** src/ppsc_sync.v ***
// two flip-flop synchroniser per bit
`timescale 1ns/1ps
module ppsc_sync #(
   parameter W = 8
) (
   // clock and reset
   input  wire         clk,
   input  wire         nrst,
   // data
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            if (!nrst) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
            end else begin
               stage1[i] <= din[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate
   assign dout = stage2;
endmodule // ppsc_sync

// *** src/ppsc_port_power_switch_control.v ***
// control logic for the usb port power switch
`timescale 1ns/1ps
`include "ppsc_consts.vh"
// What this block does
// - overcurrent clamps fast, persisting goes error
// - soft start on enable or attach
// - one limiting mode whenever switch closed
// - detect state limits to bypass capacity
// - trip overcurrent opens switch, error, alert
// - trip is default limiting mode
// - constant current in cdp, in dcp with handshake below limit 4, in dce while profile applying
// - regulation: open, step down, timer, retry
// - regulation drops accepted profile until change
// - regulation never starts active discharge
// - cc at minimum forces trip, knee lowered
// - cool restores config, timer if forced
// - trip at minimum holds closed, minimum
// - shutdown opens switch until hysteresis cleared
// - discharge on enable off, removal, uvlo, sleep, command
// - discharge on profile and recovery
// - vbus high after discharge means error
module ppsc_port_power_switch_control #(
   parameter STEP_CYC    = `PPSC_STEP_MS * 1000 * `PPSC_CLK_MHZ,
   parameter DISCH_CYC   = `PPSC_DISCH_MS * 1000 * `PPSC_CLK_MHZ,
   parameter RECOVER_CYC = `PPSC_RECOVER_MS * 1000 * `PPSC_CLK_MHZ,
   parameter RISE_CYC    = `PPSC_RISE_US * `PPSC_CLK_MHZ,
   parameter SHORT_CYC   = `PPSC_SHORT_US * `PPSC_CLK_MHZ
) (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // host controls
   input  wire       power_switch_enable,
   input  wire       emulation_enable,
   input  wire       mode_select_low,
   input  wire       mode_select_high,
   input  wire [2:0] current_limit_setting,
   input  wire       discharge_command,
   input  wire       recover_request,
   // emulation status from logic on clk
   input  wire       profile_applying,
   input  wire       profile_accepted,
   input  wire       dcp_handshake,
   // analog comparator pins
   input  wire       over_current,
   input  wire       attach_detect,
   input  wire       removal_detect,
   input  wire       supply_undervoltage,
   input  wire       over_regulation_temp,
   input  wire       under_regulation_hyst,
   input  wire       over_shutdown_temp,
   input  wire       under_shutdown_hyst,
   input  wire       vbus_below_test,
   // switch drive
   output reg        switch_closed,
   output reg        bypass_on,
   output reg        soft_start,
   output reg        current_clamp,
   output reg        trip_mode,
   output reg  [2:0] active_limit,
   output reg  [7:0] minimum_knee_current,
   output reg        discharge_on,
   output reg        profile_removed,
   // status
   output reg        error_state,
   output reg        discharge_error_flag,
   output reg        host_alert_n,
   output reg        shutdown_active
);
   localparam [2:0] ST_OFF = 3'h0, ST_DETECT = 3'h1, ST_ACTIVE = 3'h2, ST_DISCH = 3'h3;
   localparam [2:0] ST_ERROR = 3'h4, ST_SLEEP = 3'h5;
   localparam TW = 32;

   wire [8:0] pins;
   ppsc_sync #(.W(9)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  ({over_current, attach_detect, removal_detect, supply_undervoltage,
              over_regulation_temp, under_regulation_hyst, over_shutdown_temp,
              under_shutdown_hyst, vbus_below_test}),
      .dout (pins)
   );
   wire oc     = pins[8];
   wire attach = pins[7];
   wire remove = pins[6];
   wire uvlo   = pins[5];
   wire hotReg = pins[4];
   wire coolReg = pins[3];
   wire hotTsd = pins[2];
   wire coolTsd = pins[1];
   wire vbusLow = pins[0];

   reg [2:0]  state;
   reg [2:0]  next_state;
   reg        enPrev;
   reg        sleepPrev;
   reg [3:0]  ctrlPrev;
   reg        applyPrev;
   reg        regLatched;
   reg        forcedTrip;
   reg        thermalOpen;
   reg        dischGoActive;
   reg [TW-1:0] ocCount;
   reg [TW-1:0] riseCount;

   wire [1:0] mode = {mode_select_high, mode_select_low};
   wire sleepCmd = ~emulation_enable & (mode == `PPSC_MODE_PASS);
   wire [3:0] ctrlNow = {power_switch_enable, emulation_enable, mode_select_high,
                         mode_select_low};
   wire ctrlChanged = (ctrlNow != ctrlPrev);
   wire enFall = enPrev & ~power_switch_enable;
   wire enRise = ~enPrev & power_switch_enable;

   // step timer and discharge timer
   wire stepStart;
   wire stepBusy;
   wire stepDone;
   wire restoreStart;
   wire dischStart;
   wire dischBusy;
   wire dischDone;
   ppsc_timer #(.W(TW)) u_step (
      .clk   (clk),
      .nrst  (nrst),
      .start (stepStart),
      .load  (restoreStart ? RECOVER_CYC[TW-1:0] : STEP_CYC[TW-1:0]),
      .abort (shutdown_active),
      .busy  (stepBusy),
      .done  (stepDone)
   );
   ppsc_timer #(.W(TW)) u_disch (
      .clk   (clk),
      .nrst  (nrst),
      .start (dischStart),
      .load  (DISCH_CYC[TW-1:0]),
      .abort (1'b0),
      .busy  (dischBusy),
      .done  (dischDone)
   );

   wire ccWanted = (mode == `PPSC_MODE_CDP) |
                   ((mode == `PPSC_MODE_DCP) & dcp_handshake &
                    (current_limit_setting < `PPSC_LIM_DCP_MAX)) |
                   ((mode == `PPSC_MODE_DCE) & profile_applying & ~profile_removed);
   wire tripNow = ~ccWanted | forcedTrip;

   wire atMin = (active_limit == `PPSC_LIM_MIN);
   wire regTrigger = hotReg & ~stepBusy & ~thermalOpen & (state == ST_ACTIVE);

   wire dischEvent15 = enFall | remove | uvlo | (sleepCmd & ~sleepPrev) |
                       (discharge_command & (state == ST_ACTIVE));
   wire dischEvent16 = profile_applying & ~applyPrev;

   assign restoreStart = regLatched & coolReg & ~stepBusy & forcedTrip & ~thermalOpen;
   assign stepStart = (regTrigger & ~(atMin & trip_mode)) | restoreStart;
   assign dischStart = (state != ST_DISCH) & (next_state == ST_DISCH);

   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (sleepCmd) begin
               next_state = ST_SLEEP;
            end else if (power_switch_enable & ~uvlo) begin
               next_state = ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (attach & power_switch_enable & ~uvlo) begin
               next_state = ST_DISCH;
            end else if (dischEvent15) begin
               next_state = ST_DISCH;
            end
         end
         ST_ACTIVE: begin
            if (oc & (tripNow | (ocCount >= SHORT_CYC[TW-1:0]))) begin
               next_state = ST_ERROR;
            end else if (dischEvent15 | dischEvent16) begin
               next_state = ST_DISCH;
            end else if (~attach) begin
               next_state = ST_DISCH;
            end
         end
         ST_DISCH: begin
            if (dischDone) begin
               if (~vbusLow) begin
                  next_state = ST_ERROR;
               end else if (sleepCmd) begin
                  next_state = ST_SLEEP;
               end else if (~power_switch_enable | uvlo) begin
                  next_state = ST_OFF;
               end else if (dischGoActive) begin
                  next_state = ST_ACTIVE;
               end else begin
                  next_state = ST_DETECT;
               end
            end
         end
         ST_ERROR: begin
            if (recover_request) begin
               next_state = ST_DISCH;
            end
         end
         ST_SLEEP: begin
            if (~sleepCmd) begin
               next_state = ST_OFF;
            end
         end
         default: next_state = ST_OFF;
      endcase
   end

   always @(posedge clk) begin
      if (!nrst) begin
         state                <= ST_OFF;
         enPrev               <= 1'b0;
         sleepPrev            <= 1'b0;
         ctrlPrev             <= 4'h0;
         applyPrev            <= 1'b0;
         regLatched           <= 1'b0;
         forcedTrip           <= 1'b0;
         thermalOpen          <= 1'b0;
         dischGoActive        <= 1'b0;
         ocCount              <= {TW{1'b0}};
         riseCount            <= {TW{1'b0}};
         switch_closed        <= 1'b0;
         bypass_on            <= 1'b0;
         soft_start           <= 1'b0;
         current_clamp        <= 1'b0;
         trip_mode            <= 1'b1;
         active_limit         <= `PPSC_LIM_MIN;
         minimum_knee_current <= `PPSC_KNEE_NORMAL;
         discharge_on         <= 1'b0;
         profile_removed      <= 1'b0;
         error_state          <= 1'b0;
         discharge_error_flag <= 1'b0;
         host_alert_n         <= 1'b1;
         shutdown_active      <= 1'b0;
      end else begin
         state     <= next_state;
         enPrev    <= power_switch_enable;
         sleepPrev <= sleepCmd;
         ctrlPrev  <= ctrlNow;
         applyPrev <= profile_applying;
         if (state != ST_DISCH) begin
            dischGoActive <= (state == ST_DETECT) & attach;
         end

         if (hotTsd) begin
            shutdown_active <= 1'b1;
         end else if (coolTsd) begin
            shutdown_active <= 1'b0;
         end

         if (regTrigger & ~(atMin & trip_mode)) begin
            thermalOpen <= 1'b1;
            regLatched  <= 1'b1;
            if (~atMin) begin
               active_limit <= active_limit - 3'h1;
            end else if (~trip_mode) begin
               forcedTrip           <= 1'b1;
               minimum_knee_current <= `PPSC_KNEE_TRIP;
               active_limit         <= (current_limit_setting == `PPSC_LIM_MIN) ?
                                       `PPSC_LIM_MIN : current_limit_setting - 3'h1;
            end
         end else if (stepDone | shutdown_active) begin
            // abort gives no done pulse, so release here
            thermalOpen <= 1'b0;
         end
         if (regTrigger & atMin & trip_mode) begin
            regLatched <= 1'b1;
         end

         if (regLatched & coolReg & ~stepBusy) begin
            if (forcedTrip & ~thermalOpen) begin
               thermalOpen <= 1'b1;
               forcedTrip  <= 1'b0;
            end else if (~thermalOpen) begin
               regLatched           <= 1'b0;
               active_limit         <= current_limit_setting;
               minimum_knee_current <= `PPSC_KNEE_NORMAL;
            end
         end else if (~regLatched & ~thermalOpen & ~regTrigger) begin
            // first step must not be overwritten by follow
            active_limit <= current_limit_setting;
         end

         // drop accepted profile until controls change
         if (hotReg & profile_accepted & (mode == `PPSC_MODE_DCE)) begin
            profile_removed <= 1'b1;
         end else if (ctrlChanged) begin
            profile_removed <= 1'b0;
         end

         trip_mode <= tripNow;

         switch_closed <= (next_state == ST_ACTIVE) & ~hotTsd & ~shutdown_active &
                          ~thermalOpen;
         bypass_on    <= (next_state == ST_DETECT);
         discharge_on <= (next_state == ST_DISCH);

         // soft start on enable or attach
         if ((enRise | ((state == ST_DISCH) & (next_state == ST_ACTIVE))) &
             (next_state == ST_ACTIVE | state == ST_DISCH)) begin
            riseCount  <= RISE_CYC[TW-1:0];
            soft_start <= 1'b1;
         end else if (riseCount != {TW{1'b0}}) begin
            riseCount <= riseCount - {{(TW-1){1'b0}}, 1'b1};
         end else begin
            soft_start <= 1'b0;
         end

         current_clamp <= oc & (state == ST_ACTIVE);
         if (oc & (state == ST_ACTIVE)) begin
            ocCount <= ocCount + {{(TW-1){1'b0}}, 1'b1};
         end else begin
            ocCount <= {TW{1'b0}};
         end

         if (next_state == ST_ERROR) begin
            error_state  <= 1'b1;
            host_alert_n <= 1'b0;
         end else if (state == ST_ERROR) begin
            error_state  <= 1'b0;
            host_alert_n <= 1'b1;
         end
         if ((state == ST_DISCH) & dischDone & ~vbusLow) begin
            discharge_error_flag <= 1'b1;
         end else if (recover_request & (state == ST_ERROR)) begin
            discharge_error_flag <= 1'b0;
         end
      end
   end
endmodule // ppsc_port_power_switch_control

// *** tb/ppsc_load_model.sv ***
// model of the attached portable device drawing bus current
`timescale 1ns/1ps
module ppsc_load_model (
   // clock
   input  wire clk,
   // scenario controls
   input  wire plugged,
   input  wire heavy,
   input  wire stuck,
   // switch state seen on vbus
   input  wire switch_closed,
   input  wire discharge_on,
   // comparator levels
   output reg  attach_detect,
   output reg  removal_detect,
   output reg  over_current,
   output reg  vbus_below_test
);
   initial begin
      attach_detect   = 1'b0;
      removal_detect  = 1'b0;
      over_current    = 1'b0;
      vbus_below_test = 1'b1;
   end
   always @(posedge clk) begin
      attach_detect   <= plugged;
      removal_detect  <= attach_detect & ~plugged;
      // load draws only through a closed switch
      over_current    <= heavy & switch_closed;
      // held-up bus keeps vbus high after discharge
      vbus_below_test <= ~stuck & (discharge_on | ~switch_closed);
   end
endmodule // ppsc_load_model

// *** tb/ppsc_pps_monitor.sv ***
// assertion checker for the port power switch control block
`timescale 1ns/1ps
module ppsc_pps_monitor (
   // clock and reset
   input wire       clk,
   input wire       nrst,
   // inputs watched
   input wire       power_switch_enable,
   input wire       over_current,
   input wire       over_shutdown_temp,
   input wire       under_shutdown_hyst,
   input wire       vbus_below_test,
   input wire [2:0] current_limit_setting,
   // outputs watched
   input wire       switch_closed,
   input wire       bypass_on,
   input wire       soft_start,
   input wire       trip_mode,
   input wire [2:0] active_limit,
   input wire [7:0] minimum_knee_current,
   input wire       discharge_on,
   input wire       error_state,
   input wire       host_alert_n,
   input wire       shutdown_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   AST_TSD_OPEN: assert property (shutdown_active |-> !switch_closed)
      else $error("switch closed in shutdown");
   AST_TSD_SET: assert property ((over_shutdown_temp && !under_shutdown_hyst) [*3]
      |-> ##[0:3] shutdown_active) else $error("shutdown not entered");
   AST_ALERT: assert property (error_state |-> !host_alert_n)
      else $error("alert not low in error");
   AST_TRIP_OC: assert property ((trip_mode && switch_closed && over_current) [*3]
      |-> ##[0:3] !switch_closed) else $error("trip did not open switch");
   AST_BYPASS: assert property (bypass_on |-> !switch_closed)
      else $error("bypass and switch both on");
   AST_KNEE: assert property (minimum_knee_current == 8'hff
      || (minimum_knee_current == 8'h0c && trip_mode)) else $error("bad knee code");
   AST_LIMIT: assert property ($stable(current_limit_setting) [*3]
      |-> active_limit <= current_limit_setting) else $error("limit above setting");
   AST_SOFT: assert property ($rose(soft_start)
      |-> ($past(power_switch_enable) || $past(power_switch_enable, 2)))
      else $error("soft start without enable");
   AST_DISCH_EN: assert property (($fell(power_switch_enable) && switch_closed
      && !error_state) |-> ##[1:4] discharge_on) else $error("no discharge on disable");
   AST_DISCH_CHK: assert property ((discharge_on && !vbus_below_test) [*4] ##1
      !discharge_on |-> ##[0:2] error_state) else $error("discharge check missed");
endmodule // ppsc_pps_monitor
bind ppsc_port_power_switch_control ppsc_pps_monitor mon_u (
   .clk, .nrst, .power_switch_enable, .over_current, .over_shutdown_temp,
   .under_shutdown_hyst, .vbus_below_test, .current_limit_setting, .switch_closed,
   .bypass_on, .soft_start, .trip_mode, .active_limit, .minimum_knee_current,
   .discharge_on, .error_state, .host_alert_n, .shutdown_active
);

// *** tb/test_ppsc_port_power_switch_control.sv ***
// self-checking testbench for the port power switch control block
`timescale 1ns/1ps
module test_ppsc_port_power_switch_control;
   reg        clk, nrst, power_switch_enable, emulation_enable, mode_select_low;
   reg        mode_select_high, discharge_command, recover_request, profile_applying;
   reg        profile_accepted, dcp_handshake, supply_undervoltage, over_regulation_temp;
   reg        under_regulation_hyst, over_shutdown_temp, under_shutdown_hyst;
   reg        plugged, heavy, stuck;
   reg  [2:0] current_limit_setting;
   wire       over_current, attach_detect, removal_detect, vbus_below_test;
   wire       switch_closed, bypass_on, soft_start, current_clamp, trip_mode;
   wire       discharge_on, profile_removed, error_state, discharge_error_flag;
   wire       host_alert_n, shutdown_active;
   wire [2:0] active_limit;
   wire [7:0] minimum_knee_current;
   integer    error_cnt, check_count;
   // short timers keep the run brief
   ppsc_port_power_switch_control #(.STEP_CYC(20), .DISCH_CYC(20), .RECOVER_CYC(20),
      .RISE_CYC(20), .SHORT_CYC(20)) dut_u (
      .clk, .nrst, .power_switch_enable, .emulation_enable, .mode_select_low,
      .mode_select_high, .current_limit_setting, .discharge_command, .recover_request,
      .profile_applying, .profile_accepted, .dcp_handshake, .over_current, .attach_detect,
      .removal_detect, .supply_undervoltage, .over_regulation_temp, .under_regulation_hyst,
      .over_shutdown_temp, .under_shutdown_hyst, .vbus_below_test, .switch_closed,
      .bypass_on, .soft_start, .current_clamp, .trip_mode, .active_limit,
      .minimum_knee_current, .discharge_on, .profile_removed, .error_state,
      .discharge_error_flag, .host_alert_n, .shutdown_active);
   ppsc_load_model load_u (.clk, .plugged, .heavy, .stuck, .switch_closed,
      .discharge_on, .attach_detect, .removal_detect, .over_current, .vbus_below_test);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   function pick(input integer s);
      case (s)
         0: pick = switch_closed;
         1: pick = error_state;
         2: pick = discharge_on;
         3: pick = shutdown_active;
         4: pick = trip_mode;
         5: pick = bypass_on;
         default: pick = (active_limit === 3'h5);
      endcase
   endfunction
   // bounded wait, then the level is judged
   task wait_for(input integer s, input v, input integer lim);
      integer n;
      begin
         n = 0;
         while (pick(s) !== v && n < lim) begin
            tick(1);
            n = n + 1;
         end
         chk(pick(s), v);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task t_bring_up;
      begin
         power_switch_enable = 1'b1;
         wait_for(5, 1'b1, 300);
         chk(switch_closed, 1'b0);
         plugged = 1'b1;
         wait_for(2, 1'b1, 300);
         wait_for(0, 1'b1, 300);
         chk(soft_start, 1'b1);
      end
   endtask
   task t_modes;
      begin
         mode_select_high = 1'b1;
         wait_for(4, 1'b0, 300);
         mode_select_high = 1'b0;
         wait_for(4, 1'b1, 300);
         // dcp handshake with a limit below the 1.68A step
         mode_select_low = 1'b1;
         dcp_handshake = 1'b1;
         current_limit_setting = 3'h3;
         wait_for(4, 1'b0, 300);
         current_limit_setting = 3'h5;
         wait_for(4, 1'b1, 300);
         mode_select_low = 1'b0;
         dcp_handshake = 1'b0;
         wait_for(0, 1'b1, 300);
      end
   endtask
   task t_thermal;
      begin
         // accepted dce profile, so heat must drop it
         {mode_select_high, mode_select_low} = 2'h3;
         profile_accepted = 1'b1;
         over_regulation_temp = 1'b1;
         wait_for(6, 1'b0, 100);
         chk(active_limit, 3'h4);
         chk(discharge_on, 1'b0);
         chk(profile_removed, 1'b1);
         over_regulation_temp = 1'b0;
         under_regulation_hyst = 1'b1;
         wait_for(6, 1'b1, 300);
         wait_for(0, 1'b1, 300);
         under_regulation_hyst = 1'b0;
         {mode_select_high, mode_select_low} = 2'h0;
         profile_accepted = 1'b0;
         tick(1);
         chk(profile_removed, 1'b0);
      end
   endtask
   task t_shutdown;
      begin
         over_shutdown_temp = 1'b1;
         wait_for(3, 1'b1, 50);
         chk(switch_closed, 1'b0);
         over_shutdown_temp = 1'b0;
         under_shutdown_hyst = 1'b1;
         wait_for(3, 1'b0, 50);
         under_shutdown_hyst = 1'b0;
         wait_for(0, 1'b1, 300);
      end
   endtask
   task t_trip;
      begin
         heavy = 1'b1;
         wait_for(1, 1'b1, 50);
         chk(current_clamp, 1'b1);
         chk(host_alert_n, 1'b0);
         chk(switch_closed, 1'b0);
         heavy = 1'b0;
         recover_request = 1'b1;
         wait_for(2, 1'b1, 50);
         recover_request = 1'b0;
         wait_for(1, 1'b0, 300);
         chk(host_alert_n, 1'b1);
         wait_for(0, 1'b1, 300);
      end
   endtask
   task t_removal;
      begin
         plugged = 1'b0;
         wait_for(2, 1'b1, 50);
         wait_for(2, 1'b0, 300);
         plugged = 1'b1;
         wait_for(0, 1'b1, 400);
      end
   endtask
   task t_cmd_sleep;
      begin
         discharge_command = 1'b1;
         wait_for(2, 1'b1, 20);
         discharge_command = 1'b0;
         wait_for(0, 1'b1, 400);
         // pass-through with emulation off means sleep
         emulation_enable = 1'b0;
         wait_for(2, 1'b1, 20);
         wait_for(2, 1'b0, 300);
         chk(bypass_on, 1'b0);
         chk(switch_closed, 1'b0);
         emulation_enable = 1'b1;
         wait_for(0, 1'b1, 400);
      end
   endtask
   task t_discharge_error_flag;
      begin
         // bus held up so the end-of-discharge test fails
         stuck = 1'b1;
         power_switch_enable = 1'b0;
         wait_for(2, 1'b1, 20);
         wait_for(1, 1'b1, 300);
         chk(discharge_error_flag, 1'b1);
      end
   endtask
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      tally_and_finish;
   end
   initial begin
      error_cnt = 0;
      check_count = 0;
      {nrst, power_switch_enable, mode_select_low, mode_select_high} = 4'h0;
      {discharge_command, recover_request, profile_applying, profile_accepted} = 4'h0;
      {dcp_handshake, supply_undervoltage, over_regulation_temp} = 3'h0;
      {under_regulation_hyst, over_shutdown_temp, under_shutdown_hyst} = 3'h0;
      {plugged, heavy, stuck} = 3'h0;
      emulation_enable = 1'b1;
      current_limit_setting = 3'h5;
      tick(4);
      chk(trip_mode, 1'b1);
      chk(host_alert_n, 1'b1);
      chk(minimum_knee_current, 8'hff);
      chk(switch_closed, 1'b0);
      nrst = 1'b1;
      t_bring_up;
      t_modes;
      t_thermal;
      t_shutdown;
      t_trip;
      t_removal;
      t_cmd_sleep;
      t_discharge_error_flag;
      tally_and_finish;
   end
endmodule // test_ppsc_port_power_switch_control
